// File: cow_pkg.sv
// Purpose: constants for the overwrite status and mailbox 0 mask block
// Assumes: axi4-lite, 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package cow_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_OVERWRITE  = 8'h00;
	localparam logic [7:0]  OFS_MASK_LOW   = 8'h04;
	localparam logic [7:0]  OFS_MASK_HIGH  = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STATUS = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h10;
	localparam logic [7:0]  OFS_PENDING    = 8'h14;
	localparam logic [15:0] RST_REG16      = 16'h0000;
	// writable bits of the high mask; bits 12..10 are reserved
	localparam logic [15:0] MASK_HIGH_WR   = 16'he3ff;
	// ----------------------------------------------------------------
	// interrupt status bits
	// ----------------------------------------------------------------
	localparam int          IRQ_OVERWRITE  = 0;
	localparam int          IRQ_RECEIVE    = 1;
	localparam logic [1:0]  IRQ_BITS_RST   = 2'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {
		COW_IDLE = 2'b00,
		COW_RESP = 2'b01
	} cow_wstate_t;
endpackage

// File: cow_regs.sv
// Purpose: overwrite flags, receive pending flags and mailbox 0 id mask
// Assumes: receive path on the same clock as aclk
// Notes:   register fields fit in the low 16 bits of each word
//          read data and responses leave registers, reads one cycle and writes two cycles after the handshake
//
// Operation
// - sixteen overwrite flags, byte-swapped mailbox order
// - overwrite set on receive while pending
// - newer message replaces unread stored contents
// - masks apply only to mailbox 0 match
// - mask one ignores bit, zero compares
// - low mask byte-swapped onto id 15..0
// - high mask maps onto id 28..16
// - high mask bits 12..10 read zero
// - receive completion sets receive pending flag
`timescale 1ns/100ps
module cow_regs
	import cow_pkg::*;
#(
	parameter int N_MBOX = 16
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// receive path: completion pulse, target mailbox, software read done
	input  wire logic        rx_done,
	input  wire logic [3:0]  rx_mbox,
	input  wire logic [15:0] pending_clear,
	// identifier comparison for mailbox 0
	input  wire logic [28:0] rx_id,
	input  wire logic [28:0] mbox0_id,
	output logic             mbox0_match,
	// store strobe to the mailbox ram; always overwrites
	output logic             store_we,
	output logic [3:0]       store_mbox,
	output logic             irq
);
	// only the sixteen-flag layout is mapped; refuse anything else
	if (N_MBOX != 16) begin : g_bad_mbox
		$error("cow_regs serves exactly 16 mailboxes");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// register bit n holds mailbox/id bit n with bytes swapped
	// one swap serves the flags, the pending word and the low mask
	function automatic logic [15:0] swap16(input logic [15:0] v);
		return {v[7:0], v[15:8]};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0] overwrite_q;       // mailbox order, bit n = mailbox n
	logic [15:0] pending_q;         // receive_pending_flag per mailbox
	logic [15:0] mask_low_q;
	logic [15:0] mask_high_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	// write halves are held here until the response retires
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	cow_wstate_t wst_q;
	logic        match_q;
	logic        store_q;
	logic [3:0]  store_mbox_q;
	logic        irq_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        awready_q;
	logic        wready_q;
	logic        arready_q;

	// ----------------------------------------------------------------
	// write channel decode
	// ----------------------------------------------------------------
	wire         do_write  = aw_have_q && w_have_q && wst_q == COW_IDLE;
	// only the two low byte strobes matter; every field fits in 16 bits
	wire         lo_en     = w_strb_q[0];
	wire         hi_en     = w_strb_q[1];
	wire [15:0]  be_mask   = {{8{hi_en}}, {8{lo_en}}};
	wire [15:0]  wval      = w_data_q[15:0];
	wire         wr_ovw    = do_write && aw_addr_q == OFS_OVERWRITE;
	wire         wr_mlo    = do_write && aw_addr_q == OFS_MASK_LOW;
	wire         wr_mhi    = do_write && aw_addr_q == OFS_MASK_HIGH;
	wire         wr_imask  = do_write && aw_addr_q == OFS_IRQ_MASK && lo_en;
	wire         w_mapped  = aw_addr_q == OFS_OVERWRITE || aw_addr_q == OFS_MASK_LOW ||
	                         aw_addr_q == OFS_MASK_HIGH || aw_addr_q == OFS_IRQ_STATUS ||
	                         aw_addr_q == OFS_IRQ_MASK  || aw_addr_q == OFS_PENDING;

	// ----------------------------------------------------------------
	// receive events
	// ----------------------------------------------------------------
	wire [15:0]  rx_onehot = rx_done ? (16'h0001 << rx_mbox) : 16'h0000;
	wire [15:0]  ovw_set   = rx_onehot & pending_q;
	wire [15:0]  ovw_clr   = wr_ovw ? swap16(wval & be_mask) : 16'h0000;
	// the set term is ORed last, so a receive beats a W1C landing in the
	// same cycle and no overwrite is ever lost to a racing clear
	wire [15:0]  ovw_d     = (overwrite_q & ~ovw_clr) | ovw_set;
	// pending is cleared by the receive path once software has read the
	// mailbox; a new receive in that cycle keeps it set
	wire [15:0]  pend_d    = (pending_q & ~pending_clear) | rx_onehot;

	// ----------------------------------------------------------------
	// mailbox 0 acceptance
	// ----------------------------------------------------------------
	wire [15:0]  mlo_d     = (mask_low_q & ~be_mask) | (wval & be_mask);
	wire [15:0]  mhi_d     = (mask_high_q & ~(be_mask & MASK_HIGH_WR)) |
	                         (wval & be_mask & MASK_HIGH_WR);
	wire [15:0]  id_lo_dc  = swap16(mask_low_q);
	wire [12:0]  id_hi_dc  = {mask_high_q[7:0], mask_high_q[15:13], mask_high_q[9:8]};
	wire [28:0]  dont_care = {id_hi_dc, id_lo_dc};
	// a set mask bit drops that id bit from the compare; only the mailbox 0
	// match sees the masks, other mailboxes compare the full identifier
	// match is registered, so it answers one cycle after rx_id settles
	wire         match_d   = ((rx_id ^ mbox0_id) & ~dont_care) == 29'h0;

	// ----------------------------------------------------------------
	// interrupt status, cleared by reading it
	// ----------------------------------------------------------------
	wire         ar_take   = s_axi_arvalid && arready_q;
	wire         rd_istat  = ar_take && s_axi_araddr == OFS_IRQ_STATUS;
	wire [1:0]   irq_ev    = {rx_done, |ovw_set};
	// the clearing read returns the pre-clear value, and an event in the
	// same cycle survives for the next read
	wire [1:0]   istat_d   = (rd_istat ? IRQ_BITS_RST : irq_stat_q) | irq_ev; // set wins

	// ----------------------------------------------------------------
	// read data mux
	// ----------------------------------------------------------------
	// reserved high mask bits read zero here as well as being unwritable
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (s_axi_araddr)
			OFS_OVERWRITE:  rd_mux = {16'h0, swap16(overwrite_q)};
			OFS_MASK_LOW:   rd_mux = {16'h0, mask_low_q};
			OFS_MASK_HIGH:  rd_mux = {16'h0, mask_high_q & MASK_HIGH_WR};
			OFS_IRQ_STATUS: rd_mux = {30'h0, irq_stat_q};
			OFS_IRQ_MASK:   rd_mux = {30'h0, irq_mask_q};
			OFS_PENDING:    rd_mux = {16'h0, swap16(pending_q)};
			default:        rd_ok  = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overwrite_q <= RST_REG16;
			pending_q   <= RST_REG16;
			mask_low_q  <= RST_REG16;
			mask_high_q <= RST_REG16;
			irq_stat_q  <= IRQ_BITS_RST;
			irq_mask_q  <= IRQ_BITS_RST;
		end else begin
			overwrite_q <= ovw_d;
			pending_q   <= pend_d;
			irq_stat_q  <= istat_d;
			// masks change only on a write to their own word
			if (wr_mlo) mask_low_q <= mlo_d;
			if (wr_mhi) mask_high_q <= mhi_d;
			if (wr_imask) irq_mask_q <= w_data_q[1:0];
		end
	end

	// receive path outputs; store always writes, even over unread data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_q      <= 1'b0;
			store_q      <= 1'b0;
			store_mbox_q <= 4'h0;
			irq_q        <= 1'b0;
		end else begin
			match_q      <= match_d;
			store_q      <= rx_done;
			// store_mbox follows rx_mbox; only store_we qualifies it
			store_mbox_q <= rx_mbox;
			irq_q        <= |(istat_d & irq_mask_q);
		end
	end

	// write address and data captured in either order
	// the response state keeps the next write out until bready has
	// retired the current one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h0;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			wst_q     <= COW_IDLE;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			case (wst_q)
				COW_IDLE: if (do_write) wst_q <= COW_RESP;
				COW_RESP: if (s_axi_bready) begin
					wst_q     <= COW_IDLE;
					aw_have_q <= 1'b0;
					w_have_q  <= 1'b0;
				end
				default: wst_q <= COW_IDLE;
			endcase
		end
	end

	// unmapped writes still answer, with slverr, so a master never hangs
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= RESP_OKAY;
		end else if (ar_take) begin
			// data is taken once, at the address handshake
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// readies are registers so every output leaves a flip-flop; the cost
	// is an idle cycle between back-to-back transfers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			awready_q <= !aw_have_q && !(s_axi_awvalid && awready_q) && wst_q == COW_IDLE;
			wready_q  <= !w_have_q && !(s_axi_wvalid && wready_q) && wst_q == COW_IDLE;
			arready_q <= !rvalid_q && !ar_take;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign mbox0_match   = match_q;
	assign store_we      = store_q;
	assign store_mbox    = store_mbox_q;
	assign irq           = irq_q;
endmodule

// File: cow_regs_properties.sv
// Purpose: port-level checks of the store strobe, mailbox 0 match and bus answers
// Assumes: single clock, synchronous active-low reset
// Notes:   read address is tracked locally to know which word is returned
`timescale 1ns/100ps
module cow_regs_properties
	import cow_pkg::*;
#(
	parameter int N_MBOX = 16
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// receive path
	input wire logic        rx_done,
	input wire logic [3:0]  rx_mbox,
	input wire logic [28:0] rx_id,
	input wire logic [28:0] mbox0_id,
	input wire logic        mbox0_match,
	input wire logic        store_we,
	input wire logic [3:0]  store_mbox
);
	logic rd_hi_q;
	// captured at the address handshake, where the slave samples the address
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rd_hi_q <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_hi_q <= (s_axi_araddr == OFS_MASK_HIGH);
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_store; rx_done |=> store_we && store_mbox == $past(rx_mbox); endproperty
	property p_nostore; !rx_done |=> !store_we; endproperty
	property p_eqmatch; rx_id == mbox0_id |=> mbox0_match; endproperty
	property p_resv; s_axi_rvalid && rd_hi_q |-> s_axi_rdata[12:10] == 3'h0; endproperty
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	property p_rdlat; s_axi_arvalid && s_axi_arready |-> ##[0:2] s_axi_rvalid; endproperty
	property p_wrlat; s_wr_taken |-> ##[1:4] s_axi_bvalid; endproperty
	a_store: assert property (p_store) else $error("store strobe wrong");
	a_nostore: assert property (p_nostore) else $error("stray store strobe");
	a_eqmatch: assert property (p_eqmatch) else $error("equal id not matched");
	a_resv: assert property (p_resv) else $error("reserved bits not zero");
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	a_rdlat: assert property (p_rdlat) else $error("read answer late");
	a_wrlat: assert property (p_wrlat) else $error("write answer late");
endmodule
bind cow_regs cow_regs_properties #(.N_MBOX(N_MBOX)) u_props (.*);

// File: cow_can_node.sv
// Purpose: other bus nodes handing finished frames to the receive path
// Assumes: called right after a rising edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
module cow_can_node (
	// clock
	input  wire logic  aclk,
	// finished frame
	output logic        rx_done,
	output logic [3:0]  rx_mbox,
	output logic [28:0] rx_id
);
	initial begin
		rx_done = 1'b0;
		rx_mbox = 4'h0;
		rx_id = 29'h0;
	end
	// id is driven for one cycle, then inverted; the extra edge lets the registered match show it
	task automatic deliver(input logic [3:0] mb, input logic [28:0] id);
		rx_mbox <= mb;
		rx_id <= id;
		rx_done <= 1'b1;
		@(posedge aclk);
		rx_done <= 1'b0;
		rx_mbox <= ~mb;
		rx_id <= ~id;
		@(posedge aclk);
	endtask
endmodule

// File: test_cow_regs.sv
// Purpose: register and receive-path tests of the overwrite block
// Assumes: axi4-lite master tasks, outputs sampled at the rising edge
// Notes:   mask mapping is walked over all 29 id bits
`timescale 1ns/100ps
module test_cow_regs
	import cow_pkg::*;
;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, m;
	logic [3:0]  s_axi_wstrb = 0, rx_mbox, store_mbox;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        rx_done, mbox0_match, store_we, irq;
	logic [28:0] rx_id, mbox0_id = 0;
	logic [15:0] pending_clear = 0;
	int          n_mismatch = 0, cmp_count = 0;
	cow_regs u_dut (.*);
	cow_can_node u_node (.*);
	always #10 aclk = ~aclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		{ta, tw} = 2'b00;
		// one edge between calls, so a release never meets the next raise
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (!ta && s_axi_awready === 1'b1) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!tw && s_axi_wready === 1'b1) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		while (!got) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) {got, rv, rr} = {1'b1, s_axi_rdata, s_axi_rresp};
		end
		{s_axi_arvalid, s_axi_rready} <= 2'b00;
	endtask
	// low half is the low mask word, high half the high mask word
	function automatic logic [31:0] mpos(input int i);
		logic [31:0] r;
		r = 32'h0;
		if (i < 8) r[i + 8] = 1'b1;
		else if (i < 16) r[i - 8] = 1'b1;
		else if (i < 18) r[i + 8] = 1'b1;
		else if (i < 21) r[i + 11] = 1'b1;
		else r[i - 5] = 1'b1;
		return r;
	endfunction
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge aclk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			rd(8'(4 * k));
			chk(rv, 32'h0);
		end
		rd(8'h1c);
		chk(32'(rr), 32'(RESP_SLVERR));
		wr(8'h1c, 32'h0);
		chk(32'(rr), 32'(RESP_SLVERR));
		wr(OFS_MASK_HIGH, 32'h0000e3ff);
		chk(32'(rr), 32'(RESP_OKAY));
		rd(OFS_MASK_HIGH);
		chk(rv, 32'h0000e3ff);
		$display("test reset and access done");
		mbox0_id <= 29'h15a5a5a5;
		for (int i = 0; i < 29; i++) begin
			m = mpos(i);
			wr(OFS_MASK_LOW, {16'h0, m[15:0]});
			wr(OFS_MASK_HIGH, {16'h0, m[31:16]});
			u_node.deliver(4'h0, mbox0_id ^ (29'h1 << i));
			chk(32'(mbox0_match), 32'h1);
			wr(OFS_MASK_LOW, {16'h0, ~m[15:0]});
			wr(OFS_MASK_HIGH, {16'h0, ~m[31:16] & 16'he3ff});
			u_node.deliver(4'h0, mbox0_id ^ (29'h1 << i));
			chk(32'(mbox0_match), 32'h0);
		end
		$display("test mask mapping done");
		pending_clear <= 16'hffff;
		wr(OFS_OVERWRITE, 32'h0000ffff);
		pending_clear <= 16'h0;
		rd(OFS_IRQ_STATUS);
		wr(OFS_IRQ_MASK, 32'h1);
		rd(OFS_OVERWRITE);
		chk(rv, 32'h0);
		u_node.deliver(4'h3, 29'h5);
		rd(OFS_PENDING);
		chk(rv, 32'h00000800);
		chk(32'(irq), 32'h0);
		u_node.deliver(4'h3, 29'h6);
		u_node.deliver(4'hc, 29'h7);
		u_node.deliver(4'hc, 29'h8);
		rd(OFS_OVERWRITE);
		chk(rv, 32'h00000810);
		chk(32'(irq), 32'h1);
		rd(OFS_IRQ_STATUS);
		chk(rv, 32'h3);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		wr(OFS_OVERWRITE, 32'h0);
		rd(OFS_OVERWRITE);
		chk(rv, 32'h00000810);
		wr(OFS_OVERWRITE, 32'h00000800);
		pending_clear <= 16'h0008;
		rd(OFS_OVERWRITE);
		chk(rv, 32'h00000010);
		pending_clear <= 16'h0;
		u_node.deliver(4'h3, 29'h9);
		rd(OFS_OVERWRITE);
		chk(rv, 32'h00000010);
		$display("test overwrite flags done");
		finish_test();
	end
endmodule
